// ### verif/scp_uart_peer.sv
// Far-side serial peer: a remote transmitter driving the receive line.
// Assumes its tasks are called from pclk-domain bench code.
`timescale 1ns/100ps
module scp_uart_peer (
    input  wire logic pclk,
    input  wire logic ser_data_out,
    output logic      rx_data_pin
);
    logic last_seen;

    // Line idles at mark, as a stopped transmitter leaves it
    // Pin used as a plain input; port latch level is irrelevant
    initial begin
        rx_data_pin = 1'b1;
    end

    // Receiver side only watches what the device sends
    // Push-pull line assumed; open drain would need a pull-up here
    always_ff @(posedge pclk) begin
        last_seen <= ser_data_out;
    end

    // One level change just after an edge; the pin moves in step with the pclk rising edge
    task automatic drive(input logic lvl);
        @(posedge pclk);
        rx_data_pin <= lvl;
    endtask
endmodule // scp_uart_peer

// ### verif/testbench.sv
// Self-checking bench for serial channel 0 pin conditioning.
// Assumes one wait state per APB transfer and a one-cycle pready pulse.
`timescale 1ns/100ps
module testbench;
    logic        pclk;
    logic        presetn;
    logic [23:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_data;
    logic        ch_serial_out_enable;
    logic        sw_data_out_bit;
    logic        ch_run_status;
    logic        ser_data_out;
    logic        rx_data_pin;
    logic        ext_irq_zero_input;
    logic        timer_ch1_input;
    logic        rx_data_sync;
    logic        irq0_source;
    logic        timer_ch1_source;
    int          bad_count;
    int          total_checks;
    logic [31:0] rd;
    logic        er;
    logic [23:0] addr_tab [3];
    logic [31:0] mask_tab [3];

    scp_pin_cond u_scp_pin_cond (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(tx_data),
        .ch_serial_out_enable(ch_serial_out_enable),
        .sw_data_out_bit(sw_data_out_bit), .ch_run_status(ch_run_status),
        .ser_data_out(ser_data_out), .rx_data_pin(rx_data_pin),
        .ext_irq_zero_input(ext_irq_zero_input),
        .timer_ch1_input(timer_ch1_input), .rx_data_sync(rx_data_sync),
        .irq0_source(irq0_source), .timer_ch1_source(timer_ch1_source));

    scp_uart_peer u_scp_uart_peer (.pclk(pclk),
        .ser_data_out(ser_data_out), .rx_data_pin(rx_data_pin));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Holds the request until pready is sampled high; bench bound only
    task automatic apb(input logic wr, input logic [23:0] a,
                       input logic [31:0] wd, input logic [3:0] st);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin change, then old level k-1 edges on and new level at edge k
    task automatic lat(input logic lvl, input int k);
        u_scp_uart_peer.drive(lvl);
        repeat (k - 1) @(posedge pclk);
        #1 check("rx_before", {31'h0, rx_data_sync}, {31'h0, ~lvl});
        @(posedge pclk);
        #1 check("rx_after", {31'h0, rx_data_sync}, {31'h0, lvl});
        repeat (8) @(posedge pclk);
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        test_done();
    end

    initial begin
        addr_tab = '{scp_pkg::FILTER_EN_ADDR, scp_pkg::LVL_INVERT_ADDR,
                     scp_pkg::ROUTING_ADDR};
        mask_tab = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0003};
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {tx_data, ch_serial_out_enable, ch_run_status} = '0;
        {sw_data_out_bit, ext_irq_zero_input, timer_ch1_input} = 3'b111;
        bad_count = 0;
        total_checks = 0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, addr_tab[i], 32'h0, 4'hF);
            check("reg_reset", rd, 32'h0);
            apb(1'b1, addr_tab[i], 32'hFFFF_FFFF, 4'hE);
            apb(1'b0, addr_tab[i], 32'h0, 4'hF);
            check("strb_ignored", rd, 32'h0);
            apb(1'b1, addr_tab[i], 32'hFFFF_FFFF, 4'hF);
            apb(1'b0, addr_tab[i], 32'h0, 4'hF);
            check("reserved_zero", rd, mask_tab[i]);
            apb(1'b1, addr_tab[i], 32'h0, 4'hF);
        end
        apb(1'b0, 24'h0F0074, 32'h0, 4'hF);
        check("unmapped_err", {31'h0, er}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        ch_run_status <= 1'b1;
        apb(1'b1, scp_pkg::LVL_INVERT_ADDR, 32'h1, 4'hF);
        check("run_write_err", {31'h0, er}, 32'h1);
        ch_run_status <= 1'b0;
        apb(1'b0, scp_pkg::LVL_INVERT_ADDR, 32'h0, 4'hF);
        check("run_write_kept", rd, 32'h0);
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, scp_pkg::LVL_INVERT_ADDR, inv, 4'h1);
            for (int v = 0; v < 8; v++) begin
                @(posedge pclk);
                tx_data <= v[0];
                sw_data_out_bit <= v[1];
                ch_serial_out_enable <= v[2];
                repeat (2) @(posedge pclk);
                #1 check("ser_out", {31'h0, ser_data_out}, {31'h0,
                    v[2] ? (v[0] ^ inv[0]) : v[1]});
                check("peer_line", {31'h0, u_scp_uart_peer.last_seen},
                    {31'h0, v[2] ? (v[0] ^ inv[0]) : v[1]});
            end
        end
        apb(1'b1, scp_pkg::LVL_INVERT_ADDR, 32'h0, 4'h1);
        apb(1'b1, scp_pkg::FILTER_EN_ADDR, 32'h0, 4'h1);
        lat(1'b0, 3);
        lat(1'b1, 3);
        u_scp_uart_peer.drive(1'b0);
        u_scp_uart_peer.drive(1'b1);
        repeat (2) @(posedge pclk);
        #1 check("glitch_passes", {31'h0, rx_data_sync}, 32'h0);
        repeat (8) @(posedge pclk);
        apb(1'b1, scp_pkg::FILTER_EN_ADDR, 32'h1, 4'h1);
        lat(1'b0, 4);
        lat(1'b1, 4);
        u_scp_uart_peer.drive(1'b0);
        u_scp_uart_peer.drive(1'b1);
        repeat (8) begin
            @(posedge pclk);
            #1 check("glitch_held", {31'h0, rx_data_sync}, 32'h1);
        end
        u_scp_uart_peer.drive(1'b0);
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, scp_pkg::ROUTING_ADDR, r, 4'h1);
            repeat (8) @(posedge pclk);
            #1 check("irq_src", {31'h0, irq0_source},
                     {31'h0, ~r[0]});
            check("tmr_src", {31'h0, timer_ch1_source},
                  {31'h0, ~r[1]});
        end
        test_done();
    end
endmodule // testbench

// ### verilog/scp_pin_cond.sv
// Serial channel 0 pin conditioning with its APB register slave.
// Assumes tx and status inputs come from pclk logic; pins are async.
//
// Operation
// - Invert bit set inverts transmitted data level
// - Inversion applies only while serial output enabled
// - Invert register resets 00H, reserved bits zero
// - Filter on passes level after two agreeing samples
// - Filter off only synchronises the receive input
// - Filter register resets 00H, reserved bits zero
// - Routing bit 0 feeds rx to external interrupt
// - Routing bit 1 feeds rx to timer channel
// - Routing register resets 00H, reserved bits zero
// - Output disabled drives software data bit directly
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module scp_pin_cond (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [23:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_data,
    input  wire logic        ch_serial_out_enable,
    input  wire logic        sw_data_out_bit,
    input  wire logic        ch_run_status,
    output logic             ser_data_out,
    input  wire logic        rx_data_pin,
    input  wire logic        ext_irq_zero_input,
    input  wire logic        timer_ch1_input,
    output logic             rx_data_sync,
    output logic             irq0_source,
    output logic             timer_ch1_source
);

    scp_pkg::scp_ctrl_type ctrl_reg;
    scp_pkg::scp_sel_type  wr_sel_reg;
    scp_pkg::scp_sel_type  acc_sel;
    logic [2:0]            pins_sync;
    logic                  acc_issue;
    logic                  acc_done;
    logic                  wr_blocked;

    // Address decode, shared by read and write paths
    function automatic scp_pkg::scp_sel_type decode(
        input logic [23:0] addr
    );
        scp_pkg::scp_sel_type s;
        s = scp_pkg::SEL_NONE;
        if (addr == scp_pkg::FILTER_EN_ADDR) begin
            s = scp_pkg::SEL_FILTER;
        end else if (addr == scp_pkg::LVL_INVERT_ADDR) begin
            s = scp_pkg::SEL_INVERT;
        end else if (addr == scp_pkg::ROUTING_ADDR) begin
            s = scp_pkg::SEL_ROUTING;
        end
        return s;
    endfunction

    // Readback: only implemented bits, the rest read zero
    function automatic logic [31:0] read_word(
        input scp_pkg::scp_sel_type  s,
        input scp_pkg::scp_ctrl_type c
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (s)
            scp_pkg::SEL_FILTER: begin
                w[scp_pkg::FILTER_ON_BIT] = c.filter_on;
            end
            scp_pkg::SEL_INVERT: begin
                w[scp_pkg::TX_INVERT_BIT] = c.tx_invert;
            end
            scp_pkg::SEL_ROUTING: begin
                w[scp_pkg::ROUTE_IRQ_BIT]   = c.route_irq;
                w[scp_pkg::ROUTE_TIMER_BIT] = c.route_timer;
            end
            scp_pkg::SEL_NONE: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction

    assign acc_sel    = decode(paddr);
    assign acc_issue  = psel & penable & ~pready;
    assign acc_done   = psel & penable & pready;
    // Invert changes while running would corrupt a frame mid-flight
    assign wr_blocked = (acc_sel == scp_pkg::SEL_INVERT) & ch_run_status;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc_issue;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc_issue) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_word(acc_sel, ctrl_reg);
            pslverr <= (acc_sel == scp_pkg::SEL_NONE) | (pwrite & wr_blocked);
        end else begin
            pslverr <= 1'b0;
        end
    end

    // Write target picked at issue, committed at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_sel_reg <= scp_pkg::SEL_NONE;
        end else if (acc_issue && pwrite && pstrb[0] && !wr_blocked) begin
            wr_sel_reg <= acc_sel;
        end else if (acc_done) begin
            wr_sel_reg <= scp_pkg::SEL_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg.tx_invert   <= scp_pkg::LVL_INVERT_RST[scp_pkg::TX_INVERT_BIT];
            ctrl_reg.filter_on   <= scp_pkg::FILTER_EN_RST[scp_pkg::FILTER_ON_BIT];
            ctrl_reg.route_irq   <= scp_pkg::ROUTING_RST[scp_pkg::ROUTE_IRQ_BIT];
            ctrl_reg.route_timer <= scp_pkg::ROUTING_RST[scp_pkg::ROUTE_TIMER_BIT];
        end else if (acc_done) begin
            unique case (wr_sel_reg)
                scp_pkg::SEL_FILTER: begin
                    ctrl_reg.filter_on <= pwdata[scp_pkg::FILTER_ON_BIT];
                end
                scp_pkg::SEL_INVERT: begin
                    ctrl_reg.tx_invert <= pwdata[scp_pkg::TX_INVERT_BIT];
                end
                scp_pkg::SEL_ROUTING: begin
                    ctrl_reg.route_irq   <= pwdata[scp_pkg::ROUTE_IRQ_BIT];
                    ctrl_reg.route_timer <= pwdata[scp_pkg::ROUTE_TIMER_BIT];
                end
                scp_pkg::SEL_NONE: begin
                end
            endcase
        end
    end

    // Transmit pin: inversion only under serial output control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_data_out <= scp_pkg::SER_OUT_RST;
        end else if (ch_serial_out_enable) begin
            ser_data_out <= tx_data ^ ctrl_reg.tx_invert;
        end else begin
            ser_data_out <= sw_data_out_bit;
        end
    end

    // Pins: rx, interrupt, timer
    scp_sync #(
        .W   (3),
        .RST ({scp_pkg::PIN_IN_RST, scp_pkg::PIN_IN_RST,
               scp_pkg::RX_IDLE_LEVEL})
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({timer_ch1_input, ext_irq_zero_input, rx_data_pin}),
        .dout    (pins_sync)
    );

    scp_rx_filter #(
        .STABLE (scp_pkg::FILTER_STABLE_CYCLES)
    ) u_rx_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .filter_on (ctrl_reg.filter_on),
        .din       (pins_sync[0]),
        .dout      (rx_data_sync)
    );

    // Routed copies use the conditioned rx level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq0_source      <= scp_pkg::PIN_IN_RST;
            timer_ch1_source <= scp_pkg::PIN_IN_RST;
        end else begin
            irq0_source      <= ctrl_reg.route_irq ?
                                rx_data_sync : pins_sync[1];
            timer_ch1_source <= ctrl_reg.route_timer ?
                                rx_data_sync : pins_sync[2];
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_tx_invert_path: assert property (
        ch_serial_out_enable |=>
            ser_data_out == ($past(tx_data) ^ $past(ctrl_reg.tx_invert)))
        else $error("Serial output not tx data xor invert");
    a_sw_out_direct: assert property (
        !ch_serial_out_enable |=> ser_data_out == $past(sw_data_out_bit))
        else $error("Disabled output not the software bit");
    a_sw_ignores_inv: assert property (
        !ch_serial_out_enable && ctrl_reg.tx_invert ##1
        !ch_serial_out_enable |-> ser_data_out == $past(sw_data_out_bit))
        else $error("Inversion leaked into software output");
    a_invert_write: assert property (
        acc_done && wr_sel_reg == scp_pkg::SEL_INVERT |=>
            ctrl_reg.tx_invert == $past(pwdata[scp_pkg::TX_INVERT_BIT]))
        else $error("Invert register write lost");
    a_filter_write: assert property (
        acc_done && wr_sel_reg == scp_pkg::SEL_FILTER |=>
            ctrl_reg.filter_on == $past(pwdata[scp_pkg::FILTER_ON_BIT]))
        else $error("Filter register write lost");
    a_route_write: assert property (
        acc_done && wr_sel_reg == scp_pkg::SEL_ROUTING |=>
            ctrl_reg.route_irq == $past(pwdata[scp_pkg::ROUTE_IRQ_BIT]) &&
            ctrl_reg.route_timer == $past(pwdata[scp_pkg::ROUTE_TIMER_BIT]))
        else $error("Routing register write lost");
    a_reserved_zero: assert property (
        pready |-> prdata[31:2] == 30'h0000_0000)
        else $error("Reserved read bits not zero");
    a_irq_route: assert property (
        ##1 1'b1 |-> irq0_source == ($past(ctrl_reg.route_irq) ?
            $past(rx_data_sync) : $past(pins_sync[1])))
        else $error("Interrupt source mis-routed");
    a_timer_route: assert property (
        ##1 1'b1 |-> timer_ch1_source == ($past(ctrl_reg.route_timer) ?
            $past(rx_data_sync) : $past(pins_sync[2])))
        else $error("Timer source mis-routed");
    a_apb_one_wait: assert property (
        acc_issue |=> pready ##1 !pready)
        else $error("APB answer not one wait state");
    a_rx_pin_bypass: assert property (
        !ctrl_reg.filter_on [*4] |-> rx_data_sync == $past(rx_data_pin, 3))
        else $error("Unfiltered rx not three cycles after pin");

    c_invert_tx: cover property (
        ctrl_reg.tx_invert && ch_serial_out_enable ##1 !ser_data_out);
    c_route_irq_edge: cover property (
        ctrl_reg.route_irq ##1 $fell(irq0_source));
    c_unmapped_err: cover property (pready && pslverr);
    c_route_timer: cover property (
        ctrl_reg.route_timer && ctrl_reg.filter_on ##1 $rose(timer_ch1_source));
endmodule // scp_pin_cond

// ### verilog/scp_pkg.sv
// Shared constants and types for serial channel 0 pin conditioning.
// Assumes a 32-bit APB bus with 24-bit byte addresses on pclk.
package scp_pkg;

    // Register byte addresses
    localparam int          ADDR_W          = 24;
    localparam logic [23:0] FILTER_EN_ADDR  = 24'h0F0070;
    localparam logic [23:0] LVL_INVERT_ADDR = 24'h0F0134;
    localparam logic [23:0] ROUTING_ADDR    = 24'hF00730;

    // Field positions
    localparam int FILTER_ON_BIT   = 0;
    localparam int TX_INVERT_BIT   = 0;
    localparam int ROUTE_IRQ_BIT   = 0;
    localparam int ROUTE_TIMER_BIT = 1;

    // Reset values
    localparam logic [7:0] FILTER_EN_RST  = 8'h00;
    localparam logic [7:0] LVL_INVERT_RST = 8'h00;
    localparam logic [7:0] ROUTING_RST    = 8'h00;
    localparam logic       SER_OUT_RST    = 1'b1;
    localparam logic       RX_IDLE_LEVEL  = 1'b1;
    localparam logic       PIN_IN_RST     = 1'b0;

    // Samples that must agree before the filter passes a level
    localparam int FILTER_STABLE_CYCLES = 2;

    typedef enum logic [3:0] {
        SEL_NONE    = 4'b0001,
        SEL_FILTER  = 4'b0010,
        SEL_INVERT  = 4'b0100,
        SEL_ROUTING = 4'b1000
    } scp_sel_type;

    typedef struct packed {
        logic route_timer;
        logic route_irq;
        logic filter_on;
        logic tx_invert;
    } scp_ctrl_type;

endpackage

// ### verilog/scp_rx_filter.sv
// Receive noise filter: pass a level once it has been seen steadily.
// Assumes din is already synchronised to pclk.
`timescale 1ns/100ps
module scp_rx_filter #(
    parameter int STABLE = scp_pkg::FILTER_STABLE_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic filter_on,
    input  wire logic din,
    output logic      dout
);
    logic [STABLE-2:0] hist_reg;
    logic [STABLE-1:0] window;
    logic              stable;

    assign window = {hist_reg, din};
    assign stable = (&window) | ~(|window);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_reg <= {(STABLE-1){scp_pkg::RX_IDLE_LEVEL}};
        end else begin
            hist_reg <= window[STABLE-2:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout <= scp_pkg::RX_IDLE_LEVEL;
        end else if (!filter_on) begin
            dout <= din;
        end else if (stable) begin
            dout <= din;
        end
        // Disagreeing samples keep the last level
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_filt_bypass: assert property (!filter_on |=> dout == $past(din))
        else $error("Unfiltered rx does not follow sync input");
    a_filt_pass: assert property (filter_on && stable |=> dout == $past(din))
        else $error("Filtered rx missed a stable level");
    a_filt_hold: assert property (filter_on && !stable |=> $stable(dout))
        else $error("Filtered rx moved on unstable input");
    a_filt_two_agree: assert property (
        $past(filter_on) && $changed(dout) |-> $past(din) == $past(din, 2))
        else $error("Filter changed without two agreeing samples");
    c_filt_glitch: cover property (filter_on && !stable ##1 filter_on);
endmodule // scp_rx_filter

// ### verilog/scp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to pclk; only stage two is read.
`timescale 1ns/100ps
module scp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= RST;
            dout       <= RST;
        end else begin
            stage1_reg <= din;
            dout       <= stage1_reg;
        end
    end
endmodule // scp_sync
